/* pkg/default_memory_defines.vh */
`ifndef DEFAULT_MEMORY_DEFINES_VH
`define DEFAULT_MEMORY_DEFINES_VH

// apb register byte addresses
`define ADDR_DEFAULT_MEMORY_CONTROL 8'h00
`define ADDR_CHIP_SELECT_CONTROL    8'h04
`define ADDR_STATUS                 8'h08
`define ADDR_MAP_CONFIG             8'h0C

// default memory control fields
`define DMC_RESET          16'h0000
`define DMC_WAIT_HI        13
`define DMC_WAIT_LO        10
`define DMC_BURST_ALLOW    9
`define DMC_CORE_AUTO_ACK  8
`define DMC_PORT_HI        7
`define DMC_PORT_LO        6
`define DMC_ALT_AUTO_ACK   5
`define DMC_WRITE_HOLD     3
`define DMC_READ_HOLD      2
`define DMC_WRITE_MASK     16'h3FEC

// chip select control: read enable bit 0, write enable bit 1
`define CSC_READ_EN        0
`define CSC_WRITE_EN       1
`define CSC_RESET          2'h3

// port width codes
`define PORT_32            2'h0
`define PORT_8             2'h1

// bus timeout monitor, core transfers only
`define TIMEOUT_CYCLES     14'h0400

`endif

/* rtl/wait_counter.v */
`timescale 1ns/10ps
`include "default_memory_defines.vh"

module wait_counter (
  // clock and control
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       clk_en,
  // counter control
  input  wire       start,
  input  wire       clear,
  input  wire [3:0] wait_count,
  // status
  output reg        expired
);

  reg [3:0] count;
  reg       running;

  // counts from the first clock of the cycle; zero waits expire at once
  always @(posedge sys_clk) begin
    if (reset) begin
      count   <= 4'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (clk_en) begin
      // start wins: it is raised while the controller still sits in idle
      if (start) begin
        count   <= 4'h0;
        running <= (wait_count != 4'h0);
        expired <= (wait_count == 4'h0);
      end else if (clear) begin
        count   <= 4'h0;
        running <= 1'b0;
        expired <= 1'b0;
      end else if (running) begin
        if (count + 4'h1 >= wait_count) begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        count <= count + 4'h1;
      end
    end
  end

endmodule

/* rtl/default_memory_bus_control.v */
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "default_memory_defines.vh"
// Summary of operation
// - read-enable 0 keeps a chip select off on reads; 1 allows it
// - addresses outside chip-select and dram spaces are default memory
// - default memory control is 16 bits, read/write, resets to zero; writes keep only the DMC_WRITE_MASK bits (3FEC)
// - core access with auto-ack inserts wait_count waits then acknowledges
// - external acknowledge before wait expiry ends the core cycle
// - alternate master access with auto-ack waits wait_count then acknowledges
// - burst off: wide transfers split into port-sized single transfers
// - burst on: wide transfers use burst transfers
// - core auto-ack off: wait for external acknowledge only
// - core auto-ack on: unmapped core accesses end normally
// - port_width selects byte lanes: 00 32-bit, 01 8-bit, 1x 16-bit
// - alt auto-ack off: acknowledge not driven for alternate master
// - alt auto-ack on: drive acknowledge after wait count
// - alt auto-ack on: unmapped alternate accesses end normally
// - bus timeout watches core transfers only
// - write hold extend adds one clock of address, data hold after writes
// - read hold extend adds one clock of address hold after reads
// - read-enable at bit 0, write-enable bit 1, both reset to one

module default_memory_bus_control (
  // clock and control
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // core transfer request
  input  wire        core_req,
  input  wire        core_write,
  input  wire [31:0] core_addr,
  input  wire [31:0] core_wdata,
  input  wire [1:0]  core_size,
  output reg         core_done,
  output reg         core_fault,
  output reg  [31:0] core_rdata,
  // alternate master request
  input  wire        alt_req,
  input  wire        alt_write,
  input  wire [31:0] alt_addr,
  // address decode from other controllers
  input  wire        chip_select_hit,
  input  wire        dram_hit,
  // external bus pins
  input  wire        transfer_acknowledge_in,
  input  wire        async_transfer_ack_in,
  input  wire        bus_error_ack_in,
  input  wire [31:0] data_in,
  output reg         transfer_acknowledge_out,
  output wire        transfer_acknowledge_oe,
  output reg  [31:0] bus_addr,
  output reg  [31:0] data_out,
  output reg  [3:0]  lane_enable,
  output reg         bus_write,
  output reg         bus_burst,
  output reg         bus_active,
  output reg         chip_select_read_en,
  output reg         chip_select_write_en
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WAIT = 5'h02;
  localparam [4:0] ST_NEXT = 5'h04;
  localparam [4:0] ST_HOLD = 5'h08;
  localparam [4:0] ST_ALT  = 5'h10;

  localparam [13:0] TIMEOUT_LIMIT = `TIMEOUT_CYCLES;

  // registers
  reg [15:0] default_memory_control;
  reg        timeout_enable;
  reg        fault_sticky;

  wire [3:0] wait_count          = default_memory_control[`DMC_WAIT_HI:`DMC_WAIT_LO];
  wire       burst_allow         = default_memory_control[`DMC_BURST_ALLOW];
  wire       core_auto_ack       = default_memory_control[`DMC_CORE_AUTO_ACK];
  wire [1:0] port_width          = default_memory_control[`DMC_PORT_HI:`DMC_PORT_LO];
  wire       alt_master_auto_ack = default_memory_control[`DMC_ALT_AUTO_ACK];
  wire       write_hold_extend   = default_memory_control[`DMC_WRITE_HOLD];
  wire       read_hold_extend    = default_memory_control[`DMC_READ_HOLD];

  // pin synchronisers
  reg [2:0] pin_meta;
  reg [2:0] pin_sync;
  wire      ext_ack   = pin_sync[0];
  wire      ext_async = pin_sync[1];
  wire      ext_error = pin_sync[2];

  always @(posedge sys_clk) begin
    if (reset) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else if (clk_en) begin
      pin_meta <= {bus_error_ack_in, async_transfer_ack_in, transfer_acknowledge_in};
      pin_sync <= pin_meta;
    end
  end

  // apb, zero wait states
  wire apb_write = psel & penable & pwrite;
  wire apb_read  = psel & ~pwrite;
  wire addr_ok   = (paddr == `ADDR_DEFAULT_MEMORY_CONTROL) |
                   (paddr == `ADDR_CHIP_SELECT_CONTROL) |
                   (paddr == `ADDR_STATUS) | (paddr == `ADDR_MAP_CONFIG);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // beats needed per operand size: size 0 long, 1 byte, 2 word, 3 line
  function [3:0] beat_count;
    input [1:0] size;
    input [1:0] width;
    reg   [3:0] bytes;
    begin
      bytes = 4'h4;
      case (size)
        2'h1:    bytes = 4'h1;
        2'h2:    bytes = 4'h2;
        2'h3:    bytes = 4'h0;
        default: bytes = 4'h4;
      endcase
      if (width == `PORT_32)
        beat_count = (bytes == 4'h0) ? 4'h4 : 4'h1;
      else if (width == `PORT_8)
        beat_count = (bytes == 4'h0) ? 4'hF : bytes;
      else
        beat_count = (bytes == 4'h0) ? 4'h8 : ((bytes == 4'h4) ? 4'h2 : 4'h1);
    end
  endfunction

  // byte lanes per port width
  function [3:0] lanes;
    input [1:0] width;
    begin
      case (width)
        `PORT_32: lanes = 4'hF;
        `PORT_8:  lanes = 4'h8;
        default:  lanes = 4'hC;
      endcase
    end
  endfunction

  wire is_default = ~chip_select_hit & ~dram_hit;

  reg [4:0]  state;
  reg [4:0]  next_state;
  reg        from_core;
  reg [3:0]  beats_left;
  reg [13:0] timeout_count;
  reg [2:0]  byte_step;
  wire       wait_expired;
  reg        start_wait;
  reg        just_ended;

  wait_counter u_wait (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .start      (start_wait),
    .clear      (state == ST_IDLE),
    .wait_count (wait_count),
    .expired    (wait_expired)
  );

  wire auto_on   = from_core ? core_auto_ack : alt_master_auto_ack;
  wire timed_out = from_core & timeout_enable & (timeout_count >= TIMEOUT_LIMIT);
  // external acknowledge ends the cycle early even under auto-ack
  wire beat_end  = ext_ack | ext_async | (auto_on & wait_expired) |
                   (~from_core & ~alt_master_auto_ack & ext_ack);
  wire term_err  = ext_error | timed_out;
  wire hold_want = bus_write ? write_hold_extend : read_hold_extend;

  always @* begin
    next_state = state;
    start_wait = 1'b0;
    case (state)
      ST_IDLE: begin
        // requesters see the end one clock late, so that clock takes no request
        if (core_req & is_default & ~just_ended) begin
          next_state = ST_WAIT;
          start_wait = 1'b1;
        end else if (alt_req & is_default & ~just_ended) begin
          next_state = ST_ALT;
          start_wait = 1'b1;
        end
      end
      ST_WAIT: begin
        if (term_err)
          next_state = hold_want ? ST_HOLD : ST_IDLE;
        else if (beat_end)
          next_state = (beats_left > 4'h1) ? ST_NEXT : (hold_want ? ST_HOLD : ST_IDLE);
      end
      ST_NEXT: begin
        next_state = ST_WAIT;
        start_wait = 1'b1;
      end
      ST_ALT: begin
        if (ext_error | beat_end)
          next_state = hold_want ? ST_HOLD : ST_IDLE;
      end
      ST_HOLD:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // acknowledge pin is only driven for alternate masters under auto-ack
  assign transfer_acknowledge_oe = ~(((state == ST_ALT) & alt_master_auto_ack) |
                                     ~transfer_acknowledge_out);

  always @(posedge sys_clk) begin
    if (reset) begin
      state                    <= ST_IDLE;
      just_ended               <= 1'b0;
      from_core                <= 1'b0;
      beats_left               <= 4'h0;
      byte_step                <= 3'h0;
      timeout_count            <= 14'h0;
      bus_addr                 <= 32'h0;
      data_out                 <= 32'h0;
      lane_enable              <= 4'h0;
      bus_write                <= 1'b0;
      bus_burst                <= 1'b0;
      bus_active               <= 1'b0;
      core_done                <= 1'b0;
      core_fault               <= 1'b0;
      core_rdata               <= 32'h0;
      transfer_acknowledge_out <= 1'b1;
    end else if (clk_en) begin
      state                    <= next_state;
      just_ended               <= (state != ST_IDLE) & (next_state == ST_IDLE);
      core_done                <= 1'b0;
      core_fault               <= 1'b0;
      transfer_acknowledge_out <= 1'b1;
      if (state != ST_IDLE && state != ST_HOLD)
        timeout_count <= timeout_count + 14'h1;
      else
        timeout_count <= 14'h0;
      case (state)
        ST_IDLE: begin
          if (next_state == ST_WAIT) begin
            from_core   <= 1'b1;
            bus_addr    <= core_addr;
            data_out    <= core_wdata;
            bus_write   <= core_write;
            lane_enable <= lanes(port_width);
            beats_left  <= beat_count(core_size, port_width);
            byte_step   <= (port_width == `PORT_32) ? 3'h4 :
                           ((port_width == `PORT_8) ? 3'h1 : 3'h2);
            // beats are bursts only when allowed, else separate transfers
            bus_burst   <= burst_allow & (beat_count(core_size, port_width) > 4'h1);
            bus_active  <= 1'b1;
          end else if (next_state == ST_ALT) begin
            from_core   <= 1'b0;
            bus_addr    <= alt_addr;
            bus_write   <= alt_write;
            lane_enable <= lanes(port_width);
            beats_left  <= 4'h1;
            bus_burst   <= 1'b0;
            bus_active  <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (term_err | beat_end) begin
            if (~bus_write)
              core_rdata <= data_in;
            beats_left <= beats_left - 4'h1;
          end
          if (term_err) begin
            core_done  <= 1'b1;
            core_fault <= 1'b1;
            bus_active <= 1'b0;
          end else if (beat_end && beats_left <= 4'h1) begin
            core_done  <= 1'b1;
            bus_active <= 1'b0;
          end
        end
        ST_NEXT: begin
          bus_addr <= bus_addr + {29'h0, byte_step};
          data_out <= data_out << {byte_step, 3'h0};
        end
        ST_ALT: begin
          if (alt_master_auto_ack & wait_expired)
            transfer_acknowledge_out <= 1'b0;
          if (ext_error | beat_end)
            bus_active <= 1'b0;
        end
        ST_HOLD: begin
          // address and data stay one clock beyond termination
          bus_active <= 1'b0;
        end
        default: bus_active <= 1'b0;
      endcase
    end
  end

  // register writes
  always @(posedge sys_clk) begin
    if (reset) begin
      default_memory_control <= `DMC_RESET;
      chip_select_read_en    <= 1'b1;
      chip_select_write_en   <= 1'b1;
      timeout_enable         <= 1'b0;
      fault_sticky           <= 1'b0;
    end else if (clk_en) begin
      // hardware set wins over software clear
      if (state == ST_WAIT && term_err)
        fault_sticky <= 1'b1;
      else if (apb_write && paddr == `ADDR_STATUS && pwdata[0])
        fault_sticky <= 1'b0;
      if (apb_write) begin
        case (paddr)
          `ADDR_DEFAULT_MEMORY_CONTROL:
            default_memory_control <= pwdata[15:0] & `DMC_WRITE_MASK;
          `ADDR_CHIP_SELECT_CONTROL: begin
            chip_select_read_en  <= pwdata[`CSC_READ_EN];
            chip_select_write_en <= pwdata[`CSC_WRITE_EN];
          end
          `ADDR_MAP_CONFIG: timeout_enable <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  // read data registered in the setup phase
  always @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (clk_en && apb_read && !penable) begin
      case (paddr)
        `ADDR_DEFAULT_MEMORY_CONTROL: prdata <= {16'h0, default_memory_control};
        `ADDR_CHIP_SELECT_CONTROL:
          prdata <= {30'h0, chip_select_write_en, chip_select_read_en};
        `ADDR_STATUS:     prdata <= {26'h0, state, fault_sticky};
        `ADDR_MAP_CONFIG: prdata <= {31'h0, timeout_enable};
        default:          prdata <= 32'h0;
      endcase
    end
  end

endmodule

/* verification/default_memory_bus_control_assertions.sv */
`timescale 1ns/10ps
module dmbc_checker (
  // clock and reset
  input wire       sys_clk,
  input wire       reset,
  // requests
  input wire       core_req,
  input wire       alt_req,
  input wire       chip_select_hit,
  input wire       dram_hit,
  // results
  input wire       core_done,
  input wire       core_fault,
  input wire       transfer_acknowledge_out,
  input wire       transfer_acknowledge_oe,
  input wire       bus_active,
  input wire [3:0] lane_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_take;
    core_req && !bus_active && !core_done && !chip_select_hit && !dram_hit;
  endsequence
  sequence s_bus_up;
    ##[1:4] bus_active;
  endsequence

  a_core_taken: assert property (s_take |-> s_bus_up)
    else $error("core request not started");
  a_hit_ignored: assert property (!bus_active && (chip_select_hit || dram_hit) |=> !bus_active)
    else $error("mapped address started a cycle");
  a_idle_stays: assert property (!bus_active && !core_req && !alt_req |=> !bus_active)
    else $error("cycle without request");
  a_done_pulse: assert property (core_done |=> !core_done)
    else $error("done longer than one cycle");
  a_done_cause: assert property ($rose(core_done) |-> $past(bus_active))
    else $error("done without bus cycle");
  a_fault_done: assert property (core_fault |-> core_done)
    else $error("fault without done");
  a_ack_driven: assert property (!transfer_acknowledge_out |-> !transfer_acknowledge_oe)
    else $error("acknowledge asserted undriven");
  a_ack_single: assert property (!transfer_acknowledge_out |=> transfer_acknowledge_out)
    else $error("acknowledge longer than one cycle");
  a_ack_alt_only: assert property ($fell(transfer_acknowledge_out) |-> alt_req)
    else $error("acknowledge without alternate master");
  a_oe_alt_only: assert property (!transfer_acknowledge_oe |->
    alt_req || $past(alt_req) || $past(alt_req, 2))
    else $error("acknowledge driven outside alternate cycle");
  a_lanes_live: assert property (bus_active |-> lane_enable != 4'h0)
    else $error("bus cycle with no lanes");
endmodule

bind default_memory_bus_control dmbc_checker u_dmbc_checker (.sys_clk, .reset, .core_req,
  .alt_req, .chip_select_hit, .dram_hit, .core_done, .core_fault, .transfer_acknowledge_out,
  .transfer_acknowledge_oe, .bus_active, .lane_enable);

/* verification/ext_memory_model.sv */
`timescale 1ns/10ps
module ext_memory_model (
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // bench control
  input  wire        ack_en,
  input  wire        err_en,
  input  wire [3:0]  ack_delay,
  // bus from device
  input  wire        bus_active,
  input  wire        bus_write,
  input  wire        transfer_acknowledge_oe,
  input  wire [31:0] bus_addr,
  // answers
  output wire        transfer_acknowledge_in,
  output wire        async_transfer_ack_in,
  output wire        bus_error_ack_in,
  output wire [31:0] data_in
);
  reg [4:0]  cnt;
  reg [31:0] last_q;
  always @(posedge sys_clk) begin
    if (reset || !bus_active) cnt <= 5'h00;
    else if (cnt != 5'h1F) cnt <= cnt + 5'h01;
    if (reset) last_q <= 32'h00000000;
    else last_q <= data_in;
  end
  // never acknowledge while the device drives the line
  assign transfer_acknowledge_in = ack_en && transfer_acknowledge_oe && cnt >= {1'b0, ack_delay};
  assign bus_error_ack_in = err_en && cnt >= {1'b0, ack_delay};
  assign async_transfer_ack_in = 1'b0;
  // released lanes toggle so a stale word can never match
  assign data_in = (bus_active && !bus_write) ? {16'hA5C3, bus_addr[15:0]} : ~last_q;
endmodule

/* verification/default_memory_bus_control_tb.sv */
`timescale 1ns/10ps
`include "default_memory_defines.vh"
module default_memory_bus_control_tb;
  logic        sys_clk, reset, clk_en, psel, penable, pwrite, core_req, core_write, alt_req;
  logic        chip_select_hit, dram_hit, ack_en, err_en, er, flt, bst, oe_low, busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, core_addr, rd;
  logic [1:0]  core_size;
  logic [3:0]  ack_delay, lane;
  wire  [31:0] prdata, core_rdata, data_in, bus_addr;
  wire  [3:0]  lane_enable;
  wire         pready, pslverr, core_done, core_fault, transfer_acknowledge_in, bus_error_ack_in;
  wire         async_transfer_ack_in, transfer_acknowledge_out, transfer_acknowledge_oe;
  wire         bus_write, bus_burst, bus_active, chip_select_read_en, chip_select_write_en;
  int          error_cnt, check_count, cyc, gap[3];
  typedef struct {logic [1:0] port; logic b; logic w; logic [1:0] s; logic [3:0] ws;
                  logic [3:0] lane; logic eb; int cyc;} row_t;
  row_t rows[8] = '{'{0,0,0,0,0,15,0,1}, '{0,0,1,0,3,15,0,4}, '{0,0,0,0,15,15,0,16},
    '{1,0,0,0,1,8,0,0}, '{2,1,0,0,0,12,1,0}, '{3,0,1,2,2,12,0,3}, '{1,1,0,2,0,8,1,0},
    '{0,1,0,3,0,15,1,0}};

  default_memory_bus_control u_default_memory_bus_control (.sys_clk, .reset, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_req, .core_write,
    .core_addr, .core_wdata(32'h12345678), .core_size, .core_done, .core_fault, .core_rdata,
    .alt_req, .alt_write(1'b0), .alt_addr(32'h00004000), .chip_select_hit, .dram_hit,
    .transfer_acknowledge_in, .async_transfer_ack_in, .bus_error_ack_in, .data_in,
    .transfer_acknowledge_out, .transfer_acknowledge_oe, .bus_addr, .data_out(), .lane_enable,
    .bus_write, .bus_burst, .bus_active, .chip_select_read_en, .chip_select_write_en);
  ext_memory_model u_ext_memory_model (.sys_clk, .reset, .ack_en, .err_en, .ack_delay,
    .bus_active, .bus_write, .transfer_acknowledge_oe, .bus_addr, .transfer_acknowledge_in,
    .async_transfer_ack_in, .bus_error_ack_in, .data_in);

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // a gap first so a level acknowledge from the last cycle has drained
  task core(input logic w, input logic [1:0] s);
    int n;
    repeat (4) @(posedge sys_clk);
    core_req <= 1'b1;
    core_write <= w;
    core_size <= s;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (bus_active !== 1'b1 && n < 20);
    lane = lane_enable;
    bst = bus_burst;
    cyc = 0;
    while (core_done !== 1'b1 && cyc < 2000) begin
      @(negedge sys_clk);
      cyc++;
    end
    flt = core_fault;
    @(posedge sys_clk);
    core_req <= 1'b0;
  endtask
  task alt;
    int n;
    repeat (4) @(posedge sys_clk);
    alt_req <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (bus_active !== 1'b1 && n < 20);
    cyc = 0;
    oe_low = 1'b0;
    while (transfer_acknowledge_out !== 1'b0 && cyc < 12) begin
      @(negedge sys_clk);
      cyc++;
      if (transfer_acknowledge_oe !== 1'b1) oe_low = 1'b1;
    end
    @(posedge sys_clk);
    alt_req <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (bus_active !== 1'b0 && n < 40);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run;
  end
  initial begin
    {reset, psel, penable, pwrite, core_req, core_write, alt_req} = 7'h40;
    {chip_select_hit, dram_hit, ack_en, err_en, paddr, ack_delay} = 16'h0000;
    {pwdata, core_addr, core_size, clk_en} = {32'h0, 32'h00001000, 2'h0, 1'b1};
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check("cs_rd_rst", chip_select_read_en, 1);
    check("cs_wr_rst", chip_select_write_en, 1);
    apb(0, `ADDR_DEFAULT_MEMORY_CONTROL, 0);
    check("dmc_rst", rd, 0);
    apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 32'hFFFFFFFF);
    apb(0, `ADDR_DEFAULT_MEMORY_CONTROL, 0);
    check("dmc_rw", rd, 32'h00003FEC);
    // a write while the clock enable is low must not land
    clk_en <= 1'b0;
    apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 0);
    clk_en <= 1'b1;
    apb(0, `ADDR_DEFAULT_MEMORY_CONTROL, 0);
    check("frozen", rd, 32'h00003FEC);
    apb(1, 8'h10, 32'hFFFFFFFF);
    check("unmapped_wr_err", er, 1);
    apb(0, 8'h10, 0);
    check("unmapped_err", er, 1);
    check("unmapped_rd", rd, 0);
    for (int i = 0; i < 2; i++) begin
      apb(1, `ADDR_CHIP_SELECT_CONTROL, i);
      @(negedge sys_clk);
      check("cs_rd", chip_select_read_en, i);
      check("cs_wr", chip_select_write_en, 0);
    end
    foreach (rows[i]) begin
      apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, {18'h0, rows[i].ws, rows[i].b, 1'b1, rows[i].port, 6'h0});
      core(rows[i].w, rows[i].s);
      check("lanes", lane, rows[i].lane);
      check("burst", bst, rows[i].eb);
      check("no_fault", flt, 0);
      if (rows[i].cyc > 0) check("wait", cyc, rows[i].cyc);
      if (i == 0) check("rdata", core_rdata, 32'hA5C31000);
    end
    ack_en = 1'b1;
    ack_delay = 4'h1;
    apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 32'h00003D00);
    core(0, 0);
    check("early_ack", cyc < 16, 1);
    ack_delay = 4'h6;
    apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 0);
    core(0, 0);
    check("ext_ack", {cyc >= 7, flt}, 2'h2);
    ack_en = 1'b0;
    apb(1, `ADDR_MAP_CONFIG, 1);
    core(0, 0);
    check("timeout", {flt, cyc >= 1000 && cyc <= 1040}, 2'h3);
    apb(1, `ADDR_MAP_CONFIG, 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      chip_select_hit <= (i == 0);
      dram_hit <= (i == 1);
      core_req <= 1'b1;
      busy = 1'b0;
      repeat (8) begin
        @(negedge sys_clk);
        busy = busy | bus_active;
      end
      check("hit_ignored", busy, 0);
      @(posedge sys_clk);
      {core_req, chip_select_hit, dram_hit} <= 3'h0;
    end
    // request held up: clocks from done to the next cycle, no hold, read hold, write hold
    for (int i = 0; i < 3; i++) begin
      apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 32'h00000100 + 4 * i);
      core_write <= (i == 2);
      core_req <= 1'b1;
      do @(negedge sys_clk); while (core_done !== 1'b1);
      gap[i] = 0;
      do begin
        @(negedge sys_clk);
        gap[i]++;
      end while (bus_active !== 1'b1 && gap[i] < 20);
      do @(negedge sys_clk); while (core_done !== 1'b1);
      @(posedge sys_clk);
      core_req <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    check("read_hold", gap[1] - gap[0], 1);
    check("write_hold", gap[2] - gap[0], 1);
    // far side stays silent while the device owns the acknowledge
    apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 32'h00000820);
    alt;
    check("alt_wait", cyc, 3);
    check("alt_drive", oe_low, 1);
    err_en = 1'b1;
    ack_delay = 4'h2;
    apb(1, `ADDR_DEFAULT_MEMORY_CONTROL, 32'h00000800);
    alt;
    check("alt_undriven", oe_low, 0);
    err_en = 1'b0;
    complete_run;
  end
endmodule
